// ==== drv_seg_regs.sv ====
/*
  Register bank for the antenna driver segment masks, the calibration
  result display and the external field detector thresholds.
  Assumes a single-cycle register port (read data one cycle after the
  read strobe), a calibration sequencer that pulses done/fail with its
  result, and a default-setting command pulse from the command decoder.
*/
`timescale 1ns/10ps
`default_nettype none

module drv_seg_regs
  import drv_seg_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [DATA_W-1:0]   reg_rdata,
  input  wire logic                set_default,
  input  wire logic                cal_done,
  input  wire logic                cal_fail,
  input  wire logic [7:0]          cal_value,
  input  wire logic                modulated,
  output logic      [7:0]          segment_enable,
  output logic                     drivers_tristate,
  output logic      [2:0]          peer_detect_level_code,
  output logic      [3:0]          collision_avoid_level_code,
  output logic                     am_level_select
);

  // Address decode shared by the write strobes and the read checks
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = hit(addr, CAL_RESULT_OFFSET) || hit(addr, AM_MASK_OFFSET)
      || hit(addr, NORMAL_MASK_OFFSET) || hit(addr, THRESHOLD_OFFSET)
      || hit(addr, CONTROL_OFFSET);
  endfunction

  logic [7:0] cal_result_reg;
  logic [7:0] cal_result_next;
  logic [7:0] am_mask_reg;
  logic [7:0] am_mask_next;
  logic [7:0] normal_mask_reg;
  logic [7:0] normal_mask_next;
  logic [2:0] peer_reg;
  logic [2:0] peer_next;
  logic [3:0] coll_reg;
  logic [3:0] coll_next;
  logic       select_reg;
  logic       select_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       wr_am;
  logic       wr_normal;
  logic       wr_thr;
  logic       wr_ctl;

  always_comb begin
    wr_am     = reg_write && hit(reg_addr, AM_MASK_OFFSET);
    wr_normal = reg_write && hit(reg_addr, NORMAL_MASK_OFFSET);
    wr_thr    = reg_write && hit(reg_addr, THRESHOLD_OFFSET);
    wr_ctl    = reg_write && hit(reg_addr, CONTROL_OFFSET);
  end

  // Calibration result: only the sequencer and the default command write it, the bus cannot
  always_comb begin
    cal_result_next = cal_result_reg;
    if (set_default) begin
      cal_result_next = CAL_RESULT_RESET;
    end else if (cal_fail) begin
      cal_result_next = CAL_FAIL_VALUE;
    end else if (cal_done) begin
      cal_result_next = cal_value;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cal_result_reg <= CAL_RESULT_RESET;
    end else begin
      cal_result_reg <= cal_result_next;
    end
  end

  // Writable configuration; the default command wins over a same-cycle write
  always_comb begin
    am_mask_next     = am_mask_reg;
    normal_mask_next = normal_mask_reg;
    peer_next        = peer_reg;
    coll_next        = coll_reg;
    select_next      = select_reg;
    if (set_default) begin
      am_mask_next     = MASK_RESET;
      normal_mask_next = MASK_RESET;
      peer_next        = PEER_CODE_RESET;
      coll_next        = COLL_CODE_RESET;
      select_next      = 1'b0;
    end else begin
      if (wr_am) begin
        am_mask_next = reg_wdata;
      end
      if (wr_normal) begin
        normal_mask_next = reg_wdata;
      end
      if (wr_thr) begin
        peer_next = reg_wdata[PEER_CODE_MSB:PEER_CODE_LSB];
        coll_next = reg_wdata[COLL_CODE_MSB:COLL_CODE_LSB];
      end
      if (wr_ctl) begin
        select_next = reg_wdata[AM_SELECT_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      am_mask_reg     <= MASK_RESET;
      normal_mask_reg <= MASK_RESET;
      peer_reg        <= PEER_CODE_RESET;
      coll_reg        <= COLL_CODE_RESET;
      select_reg      <= 1'b0;
    end else begin
      am_mask_reg     <= am_mask_next;
      normal_mask_reg <= normal_mask_next;
      peer_reg        <= peer_next;
      coll_reg        <= coll_next;
      select_reg      <= select_next;
    end
  end

  // Read port; unmapped addresses and unused bits read as zero
  always_comb begin
    rdata_next = READ_IDLE;
    if (reg_read) begin
      case (reg_addr)
        CAL_RESULT_OFFSET:  rdata_next = cal_result_reg;
        AM_MASK_OFFSET:     rdata_next = am_mask_reg;
        NORMAL_MASK_OFFSET: rdata_next = normal_mask_reg;
        THRESHOLD_OFFSET:   rdata_next = {1'b0, peer_reg, coll_reg};
        CONTROL_OFFSET:     rdata_next = {select_reg, 7'h00};
        default:            rdata_next = READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_reg <= READ_IDLE;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata                  = rdata_reg;
  assign peer_detect_level_code     = peer_reg;
  assign collision_avoid_level_code = coll_reg;
  assign am_level_select            = select_reg;

  // Result bits are segment-off marks, applied when modulated with level select clear
  // Bit order keeps the 2..256 Ohm binary weighting
  drv_seg_select u_select (
    .clock            (clock),
    .rst              (rst),
    .modulated        (modulated),
    .am_level_select  (select_reg),
    .cal_mask         (cal_result_reg),
    .am_mask          (am_mask_reg),
    .normal_mask      (normal_mask_reg),
    .segment_enable   (segment_enable),
    .drivers_tristate (drivers_tristate)
  );

  sequence cal_fail_seq;
    cal_fail && !set_default;
  endsequence

  sequence read_result_seq;
    reg_read && reg_addr == CAL_RESULT_OFFSET;
  endsequence

  cal_fail_load_a: assert property (@(posedge clock) disable iff (rst)
    cal_fail_seq |=> cal_result_reg == CAL_FAIL_VALUE)
    else $error("failed calibration did not load all ones");

  cal_default_clear_a: assert property (@(posedge clock) disable iff (rst)
    set_default |=> cal_result_reg == CAL_RESULT_RESET && am_mask_reg == MASK_RESET
      && normal_mask_reg == MASK_RESET)
    else $error("default command did not clear result and masks");

  cal_ro_a: assert property (@(posedge clock) disable iff (rst)
    (reg_write && !cal_done && !cal_fail && !set_default) |=> $stable(cal_result_reg))
    else $error("calibration result changed on a bus write");

  result_read_a: assert property (@(posedge clock) disable iff (rst)
    read_result_seq ##0 (!cal_done && !cal_fail && !set_default)
      |=> reg_rdata == cal_result_reg)
    else $error("calibration result read back wrongly");

  thr_default_a: assert property (@(posedge clock) disable iff (rst)
    set_default |=> peer_detect_level_code == PEER_CODE_RESET
      && collision_avoid_level_code == COLL_CODE_RESET)
    else $error("threshold codes not restored by default command");

  thr_write_a: assert property (@(posedge clock) disable iff (rst)
    (wr_thr && !set_default) |=> collision_avoid_level_code == $past(reg_wdata[3:0])
      && peer_detect_level_code == $past(reg_wdata[6:4]))
    else $error("threshold write not stored");

  sequence cal_ok_seq;
    cal_done && !cal_fail && !set_default;
  endsequence

  sequence bus_write_seq;
    reg_write && !set_default;
  endsequence

  sequence read_unmapped_seq;
    reg_read && !is_mapped(reg_addr);
  endsequence

  sequence modulated_cal_seq;
    modulated && !select_reg;
  endsequence

  sequence default_clash_seq;
    set_default && (reg_write || cal_fail || cal_done);
  endsequence

  // Checks on the register side
  cal_done_load_a: assert property (@(posedge clock) disable iff (rst)
    cal_ok_seq |=> cal_result_reg == $past(cal_value))
    else $error("calibration result not loaded on done");

  default_clash_a: assert property (@(posedge clock) disable iff (rst)
    default_clash_seq |=> cal_result_reg == CAL_RESULT_RESET
      && am_mask_reg == MASK_RESET && !select_reg)
    else $error("default command lost to a same-cycle event");

  cal_ignore_write_a: assert property (@(posedge clock) disable iff (rst)
    bus_write_seq ##0 hit(reg_addr, CAL_RESULT_OFFSET) ##0 (!cal_done && !cal_fail)
      |=> cal_result_reg == $past(cal_result_reg))
    else $error("bus write reached the calibration result");

  am_mask_write_a: assert property (@(posedge clock) disable iff (rst)
    bus_write_seq ##0 hit(reg_addr, AM_MASK_OFFSET)
      |=> am_mask_reg == $past(reg_wdata))
    else $error("modulated mask write not stored");

  normal_mask_write_a: assert property (@(posedge clock) disable iff (rst)
    bus_write_seq ##0 hit(reg_addr, NORMAL_MASK_OFFSET)
      |=> normal_mask_reg == $past(reg_wdata))
    else $error("normal mask write not stored");

  ctl_write_a: assert property (@(posedge clock) disable iff (rst)
    bus_write_seq ##0 hit(reg_addr, CONTROL_OFFSET)
      |=> am_level_select == $past(reg_wdata[AM_SELECT_BIT]))
    else $error("level select write not stored");

  select_default_a: assert property (@(posedge clock) disable iff (rst)
    set_default |=> !am_level_select)
    else $error("level select not cleared by default command");

  thr_hold_a: assert property (@(posedge clock) disable iff (rst)
    !(wr_thr || set_default) |=> $stable(peer_detect_level_code))
    else $error("peer threshold changed without a write");

  read_idle_a: assert property (@(posedge clock) disable iff (rst)
    !reg_read |=> reg_rdata == READ_IDLE)
    else $error("read data not idle outside a read");

  unmapped_read_a: assert property (@(posedge clock) disable iff (rst)
    read_unmapped_seq |=> reg_rdata == READ_IDLE)
    else $error("unmapped address read back non-zero");

  thr_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && hit(reg_addr, THRESHOLD_OFFSET)
      |=> reg_rdata == {1'b0, $past(peer_reg), $past(coll_reg)})
    else $error("threshold register read back wrongly");

  ctl_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && hit(reg_addr, CONTROL_OFFSET)
      |=> reg_rdata == {$past(select_reg), 7'h00})
    else $error("control bits read back wrongly");

  am_mask_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && hit(reg_addr, AM_MASK_OFFSET)
      |=> reg_rdata == $past(am_mask_reg))
    else $error("modulated mask read back wrongly");

  normal_mask_read_a: assert property (@(posedge clock) disable iff (rst)
    reg_read && hit(reg_addr, NORMAL_MASK_OFFSET)
      |=> reg_rdata == $past(normal_mask_reg))
    else $error("normal mask read back wrongly");

  // Checks on the segment side
  cal_seg_off_a: assert property (@(posedge clock) disable iff (rst)
    modulated_cal_seq |=> (segment_enable & $past(cal_result_reg)) == 8'h00)
    else $error("segment marked by calibration result left enabled");

  tristate_clear_a: assert property (@(posedge clock) disable iff (rst)
    (normal_mask_reg != ALL_SEGMENTS_OFF) |=> !drivers_tristate)
    else $error("drivers tristate without all-ones normal mask");

  // Bit i of a mask removes the segment of nominal weight 2^(8-i) Ohm;
  // a bit that steered its neighbour would break the binary weighting
  for (genvar i = 0; i < 8; i++) begin : g_seg_bit
    seg_bit_off_a: assert property (@(posedge clock) disable iff (rst)
      (!modulated && normal_mask_reg[i]) |=> !segment_enable[i])
      else $error("normal mask bit left its segment enabled");
    seg_bit_on_a: assert property (@(posedge clock) disable iff (rst)
      (!modulated && !normal_mask_reg[i]) |=> segment_enable[i])
      else $error("segment disabled without its normal mask bit");
  end

  reset_values_a: assert property (@(posedge clock)
    rst |=> cal_result_reg == CAL_RESULT_RESET && am_mask_reg == MASK_RESET
      && normal_mask_reg == MASK_RESET && peer_reg == PEER_CODE_RESET
      && coll_reg == COLL_CODE_RESET && !select_reg
      && reg_rdata == READ_IDLE)
    else $error("register not at its reset value after reset");

endmodule // drv_seg_regs

`default_nettype wire

// ==== drv_seg_pkg.sv ====
/*
  Constants for the driver segment and field threshold register group:
  register offsets, field positions, reset values, enumerations.
  Assumes nothing of its surroundings; imported by every design file.
*/
`default_nettype none

package drv_seg_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] CAL_RESULT_OFFSET = 8'h25;
  localparam logic [7:0] AM_MASK_OFFSET    = 8'h26;
  localparam logic [7:0] NORMAL_MASK_OFFSET = 8'h27;
  localparam logic [7:0] THRESHOLD_OFFSET  = 8'h29;
  localparam logic [7:0] CONTROL_OFFSET    = 8'h24;

  localparam logic [7:0] CAL_RESULT_RESET  = 8'h00;
  localparam logic [7:0] CAL_FAIL_VALUE    = 8'hFF;
  localparam logic [7:0] MASK_RESET        = 8'h00;
  localparam logic [7:0] ALL_SEGMENTS_OFF  = 8'hFF;

  localparam int unsigned PEER_CODE_LSB    = 4;
  localparam int unsigned PEER_CODE_MSB    = 6;
  localparam int unsigned COLL_CODE_LSB    = 0;
  localparam int unsigned COLL_CODE_MSB    = 3;
  localparam logic [2:0]  PEER_CODE_RESET  = 3'h3;
  localparam logic [3:0]  COLL_CODE_RESET  = 4'h3;
  localparam logic [7:0]  THRESHOLD_USED   = 8'h7F;

  localparam int unsigned AM_SELECT_BIT    = 7;
  localparam logic [7:0]  CONTROL_USED     = 8'h80;
  localparam logic [7:0]  READ_IDLE        = 8'h00;

  typedef enum logic [1:0] {
    SRC_CAL,
    SRC_MASK
  } am_source_e;

endpackage : drv_seg_pkg

`default_nettype wire

// ==== drv_seg_select.sv ====
/*
  Segment enable selector: picks the mask that applies to the present
  transmitter state and turns it into active-high segment enables.
  Assumes masks come straight from registers; output is a flip-flop.
*/
`timescale 1ns/10ps
`default_nettype none

module drv_seg_select
  import drv_seg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        modulated,
  input  wire logic        am_level_select,
  input  wire logic [7:0]  cal_mask,
  input  wire logic [7:0]  am_mask,
  input  wire logic [7:0]  normal_mask,
  output logic      [7:0]  segment_enable,
  output logic             drivers_tristate
);

  logic [7:0] enable_reg;
  logic [7:0] enable_next;
  logic       tri_reg;
  logic       tri_next;
  logic [7:0] mask_sel;

  always_comb begin
    if (!modulated) begin
      mask_sel = normal_mask;
    end else if (am_level_select) begin
      mask_sel = am_mask;
    end else begin
      mask_sel = cal_mask;
    end
    enable_next = ~mask_sel;
    tri_next    = (normal_mask == ALL_SEGMENTS_OFF);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      enable_reg <= 8'hFF;
      tri_reg    <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      tri_reg    <= tri_next;
    end
  end

  assign segment_enable   = enable_reg;
  assign drivers_tristate = tri_reg;

  tristate_hold_a: assert property (@(posedge clock) disable iff (rst)
    (normal_mask == ALL_SEGMENTS_OFF) |=> drivers_tristate)
    else $error("drivers not tristate after all-ones normal mask");

  normal_select_a: assert property (@(posedge clock) disable iff (rst)
    !modulated |=> segment_enable == ~$past(normal_mask))
    else $error("normal state enables do not follow normal mask");

  am_select_a: assert property (@(posedge clock) disable iff (rst)
    (modulated && am_level_select) |=> segment_enable == ~$past(am_mask))
    else $error("modulated enables do not follow writable mask");

  cal_select_a: assert property (@(posedge clock) disable iff (rst)
    (modulated && !am_level_select) |=> segment_enable == ~$past(cal_mask))
    else $error("modulated enables do not follow calibration result");

endmodule // drv_seg_select

`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking bench for the driver segment and field threshold registers.
  Assumes drv_seg_regs as top, register port with read data one cycle late.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import drv_seg_pkg::*;

  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       set_default = 1'b0;
  logic       cal_done = 1'b0;
  logic       cal_fail = 1'b0;
  logic [7:0] cal_value = 8'h00;
  logic       modulated = 1'b0;
  logic [7:0] segment_enable;
  logic       drivers_tristate;
  logic [2:0] peer_detect_level_code;
  logic [3:0] collision_avoid_level_code;
  logic       am_level_select;
  int         miscompares = 0;
  int         n_tests = 0;
  int         cycles = 0;

  drv_seg_regs u_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .set_default(set_default), .cal_done(cal_done), .cal_fail(cal_fail),
    .cal_value(cal_value), .modulated(modulated), .segment_enable(segment_enable),
    .drivers_tristate(drivers_tristate), .peer_detect_level_code(peer_detect_level_code),
    .collision_avoid_level_code(collision_avoid_level_code),
    .am_level_select(am_level_select)
  );

  always #5 clock = ~clock;

  // Whole run needs about 110 cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares = miscompares + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Registered outputs trail their sources by up to two edges
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic cal_pulse(input logic ok, input logic bad, input logic [7:0] v);
    @(posedge clock);
    cal_done  <= ok;
    cal_fail  <= bad;
    cal_value <= v;
    @(posedge clock);
    cal_done  <= 1'b0;
    cal_fail  <= 1'b0;
  endtask

  task automatic check_defaults();
    rd(CAL_RESULT_OFFSET, 8'h00);
    rd(AM_MASK_OFFSET, 8'h00);
    rd(NORMAL_MASK_OFFSET, 8'h00);
    rd(THRESHOLD_OFFSET, 8'h33);
    rd(CONTROL_OFFSET, 8'h00);
    chk(segment_enable, 8'hFF);
    chk({7'h00, drivers_tristate}, 8'h00);
    chk({5'h00, peer_detect_level_code}, 8'h03);
    chk({4'h0, collision_avoid_level_code}, 8'h03);
  endtask

  task automatic test_access();
    wr(AM_MASK_OFFSET, 8'hA5);
    wr(NORMAL_MASK_OFFSET, 8'h3C);
    wr(THRESHOLD_OFFSET, 8'hFA);
    wr(CAL_RESULT_OFFSET, 8'h77);
    wr(CONTROL_OFFSET, 8'hFF);
    wr(8'h28, 8'h55);
    rd(AM_MASK_OFFSET, 8'hA5);
    rd(NORMAL_MASK_OFFSET, 8'h3C);
    rd(THRESHOLD_OFFSET, 8'h7A);
    rd(CAL_RESULT_OFFSET, 8'h00);
    rd(CONTROL_OFFSET, 8'h80);
    rd(8'h28, 8'h00);
    chk({5'h00, peer_detect_level_code}, 8'h07);
    chk({4'h0, collision_avoid_level_code}, 8'h0A);
    chk({7'h00, am_level_select}, 8'h01);
  endtask

  task automatic test_cal();
    cal_pulse(1'b1, 1'b0, 8'h5A);
    rd(CAL_RESULT_OFFSET, 8'h5A);
    cal_pulse(1'b1, 1'b1, 8'h12);
    rd(CAL_RESULT_OFFSET, 8'hFF);
    cal_pulse(1'b1, 1'b0, 8'h81);
    rd(CAL_RESULT_OFFSET, 8'h81);
  endtask

  task automatic test_segments();
    wr(NORMAL_MASK_OFFSET, 8'hC0);
    @(posedge clock);
    modulated <= 1'b0;
    settle();
    chk(segment_enable, 8'h3F);
    @(posedge clock);
    modulated <= 1'b1;
    settle();
    chk(segment_enable, 8'h5A);
    wr(CONTROL_OFFSET, 8'h00);
    settle();
    chk(segment_enable, 8'h7E);
    wr(NORMAL_MASK_OFFSET, 8'hFF);
    @(posedge clock);
    modulated <= 1'b0;
    settle();
    chk({7'h00, drivers_tristate}, 8'h01);
    chk(segment_enable, 8'h00);
  endtask

  task automatic test_default();
    @(posedge clock);
    set_default <= 1'b1;
    reg_write   <= 1'b1;
    reg_addr    <= AM_MASK_OFFSET;
    reg_wdata   <= 8'h77;
    cal_fail    <= 1'b1;
    @(posedge clock);
    set_default <= 1'b0;
    reg_write   <= 1'b0;
    cal_fail    <= 1'b0;
    settle();
    check_defaults();
  endtask

  // Reset in mid-run must restore every register, as at power-up
  task automatic test_reset();
    wr(NORMAL_MASK_OFFSET, 8'h18);
    wr(THRESHOLD_OFFSET, 8'h45);
    cal_pulse(1'b0, 1'b1, 8'h00);
    rd(CAL_RESULT_OFFSET, 8'hFF);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    check_defaults();
  endtask

  // Strobes back to back with no idle cycle between them
  task automatic test_back_to_back();
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr  <= AM_MASK_OFFSET;
    reg_wdata <= 8'h96;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clock);
    reg_addr  <= THRESHOLD_OFFSET;
    #1;
    chk(reg_rdata, 8'h96);
    @(posedge clock);
    reg_read  <= 1'b0;
    #1;
    chk(reg_rdata, 8'h33);
    @(posedge clock);
    #1;
    chk(reg_rdata, 8'h00);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1;
    check_defaults();
    test_access();
    test_cal();
    test_segments();
    test_default();
    test_reset();
    test_back_to_back();
    complete_run();
  end

endmodule // tb_top

`default_nettype wire
